//--- inc/oad_consts.svh
// constants for the operand addressing decoder
`ifndef OAD_CONSTS_SVH
`define OAD_CONSTS_SVH
`define OAD_PC_W 12
`define OAD_STACK_DEPTH 6
`define OAD_PC_RESET 12'h000
`define OAD_WORK_BASE 8'h80
`define OAD_WORK_LAST 8'h83
`define OAD_ACC_ADDR 8'hFF
`define OAD_PERI_BASE 8'hC0
`define OAD_RAM_BASE 8'h40
`define OAD_REL_LAST 3'h3
`define OAD_CLS_EXT 3'h4
`define OAD_CLS_BIT 3'h5
`define OAD_CLS_MEM 3'h6
`define OAD_CLS_INX 3'h7
`define OAD_MEM_IMM 2'h0
`define OAD_MEM_DIR 2'h1
`endif

//--- inc/oad_pkg.sv
// types for the operand addressing decoder
`default_nettype none
package oad_pkg;
   typedef enum logic [3:0] {
      M_IMM = 4'h0, M_DIR = 4'h1, M_SDIR = 4'h2, M_EXT = 4'h3, M_REL = 4'h4,
      M_BDIR = 4'h5, M_BTB = 4'h6, M_IND = 4'h7, M_INH = 4'h8
   } oad_mode_e;
   typedef enum logic [2:0] {
      R_NONE = 3'h0, R_PROG = 3'h1, R_ACC = 3'h2, R_WORK = 3'h3,
      R_PERI = 3'h4, R_RAM = 3'h5, R_DROM = 3'h6
   } oad_region_e;
   typedef struct packed {
      oad_mode_e mode;
      logic [1:0] len;
      logic data_rd;
   } oad_class_s;
   typedef struct packed {
      oad_mode_e mode;
      logic [1:0] len;
      logic [7:0] opcode;
      logic [7:0] operand;
      logic [2:0] bitnum;
      logic [11:0] target;
      logic taken;
      oad_region_e region;
   } oad_decode_s;
endpackage : oad_pkg
`default_nettype wire

//--- core/oad_opclass.sv
// opcode classifier: mode and length from the opcode byte alone
`include "oad_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module oad_opclass (
   input wire logic [7:0] opcode_in,
   output var oad_pkg::oad_class_s class_out
);
   wire [2:0] top = opcode_in[7:5];
   wire is_rel = top <= `OAD_REL_LAST;
   wire is_ext = top == `OAD_CLS_EXT;
   wire is_bdir = (top == `OAD_CLS_BIT) && !opcode_in[3];
   wire is_btb = (top == `OAD_CLS_BIT) && opcode_in[3];
   wire is_imm = (top == `OAD_CLS_MEM) && (opcode_in[4:3] == `OAD_MEM_IMM);
   wire is_dir = (top == `OAD_CLS_MEM) && (opcode_in[4:3] == `OAD_MEM_DIR);
   wire is_sdir = (top == `OAD_CLS_MEM) && opcode_in[4];
   wire is_ind = (top == `OAD_CLS_INX) && opcode_in[3];
   wire one_byte = is_rel | is_sdir | is_ind | !(is_ext | is_bdir | is_btb | is_imm | is_dir);
   oad_pkg::oad_mode_e mode;
   assign mode = is_rel ? oad_pkg::M_REL :
                 is_ext ? oad_pkg::M_EXT :
                 is_bdir ? oad_pkg::M_BDIR :
                 is_btb ? oad_pkg::M_BTB :
                 is_imm ? oad_pkg::M_IMM :
                 is_dir ? oad_pkg::M_DIR :
                 is_sdir ? oad_pkg::M_SDIR :
                 is_ind ? oad_pkg::M_IND : oad_pkg::M_INH;
   assign class_out.mode = mode;
   assign class_out.len = is_btb ? 2'd3 : (one_byte ? 2'd1 : 2'd2);
   assign class_out.data_rd = is_ind | is_btb;
endmodule : oad_opclass
`default_nettype wire

//--- core/oad_ret_stack.sv
// return address stack of twelve-bit cells
`include "oad_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module oad_ret_stack #(
   parameter int DEPTH = `OAD_STACK_DEPTH,
   parameter int W = `OAD_PC_W,
   parameter int CW = $clog2(DEPTH + 1)
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic [W-1:0] data_in,
   output logic [W-1:0] top_out,
   output logic [CW-1:0] count_out,
   output logic full_out,
   output logic empty_out
);
   logic [W-1:0] mem [DEPTH];
   logic [CW-1:0] count;
   wire do_push = push_in && !full_out;
   wire do_pop = pop_in && !push_in && !empty_out;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         count <= '0;
      end else if (do_push) begin
         count <= CW'(count + 1'b1);
      end else if (do_pop) begin
         count <= CW'(count - 1'b1);
      end
   end
   always_ff @(posedge clk_in) begin
      if (do_push) begin
         mem[count] <= data_in;
      end
   end
   assign full_out = count == CW'(DEPTH);
   assign empty_out = count == '0;
   assign count_out = count;
   assign top_out = empty_out ? '0 : mem[CW'(count - 1'b1)];
endmodule : oad_ret_stack
`default_nettype wire

//--- core/oad_decoder.sv
// operand addressing decoder: fetch, mode decode, branch target, return stack
// Contract
// - six twelve-bit return cells for calls, interrupts
// - data space holds accumulator, registers, ports, RAM, constants
// - immediate operand is the byte after opcode
// - direct: next byte addresses any data byte
// - short direct: opcode selects register 80h to 83h
// - extended: low opcode nibble joined with next byte
// - long jump and call reach whole program space
// - relative branch spans -15..+16, else falls through
// - relative opcode: condition, direction, four-bit span
// - bit direct: opcode bit number, next byte address
// - bit test branch: three bytes, displacement -127..+128
// - indirect via index 80h or 81h, opcode bit 4
// - inherent: one byte, opcode alone
`include "oad_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module oad_decoder #(
   parameter int STACK_DEPTH = `OAD_STACK_DEPTH,
   parameter int SCW = $clog2(STACK_DEPTH + 1)
) (
   input wire logic CORE_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic START_IN,
   input wire logic [11:0] PC_IN,
   input wire logic FLAG_Z_IN,
   input wire logic FLAG_C_IN,
   input wire logic IRQ_PUSH_IN,
   input wire logic RET_POP_IN,
   output logic PROG_RD_OUT,
   output logic [11:0] PROG_ADDR_OUT,
   input wire logic [7:0] PROG_DATA_IN,
   output logic DATA_RD_OUT,
   output logic [7:0] DATA_ADDR_OUT,
   input wire logic [7:0] DATA_IN,
   output logic BUSY_OUT,
   output logic DONE_OUT,
   output var oad_pkg::oad_decode_s DECODE_OUT,
   output logic [11:0] NEXT_PC_OUT,
   output logic [11:0] STACK_TOP_OUT,
   output logic STACK_FULL_OUT,
   output logic STACK_EMPTY_OUT
);
   typedef enum logic [3:0] {
      S_IDLE = 4'b0000, S_OPC_A = 4'b0001, S_OPC_B = 4'b0010,
      S_B1_A = 4'b0011, S_B1_B = 4'b0100, S_B2_A = 4'b0101,
      S_B2_B = 4'b0110, S_DAT_A = 4'b0111, S_DAT_B = 4'b1000,
      S_DONE = 4'b1001
   } oad_state_e;

   oad_state_e state;
   oad_state_e next_state;
   logic [11:0] pc_q;
   logic [7:0] opc_q;
   logic [7:0] b1_q;
   logic [7:0] b2_q;
   logic [7:0] dat_q;
   logic [SCW-1:0] stack_count;
   oad_pkg::oad_class_s cls;
   oad_pkg::oad_decode_s next_decode;

   // operand sources, live in the capture cycle
   wire [7:0] op_w = (state == S_OPC_B) ? PROG_DATA_IN : opc_q;
   wire [7:0] b1_w = (state == S_B1_B) ? PROG_DATA_IN : b1_q;
   wire [7:0] b2_w = (state == S_B2_B) ? PROG_DATA_IN : b2_q;
   wire [7:0] dat_w = (state == S_DAT_B) ? DATA_IN : dat_q;
   wire [1:0] cls_len = cls.len;

   oad_opclass u_opclass (
      .opcode_in(op_w),
      .class_out(cls)
   );

   // sequencing
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (START_IN) begin
               next_state = S_OPC_A;
            end
         end
         S_OPC_A: next_state = S_OPC_B;
         S_OPC_B: begin
            if (cls.len != 2'd1) begin
               next_state = S_B1_A;
            end else if (cls.data_rd) begin
               next_state = S_DAT_A;
            end else begin
               next_state = S_DONE;
            end
         end
         S_B1_A: next_state = S_B1_B;
         S_B1_B: next_state = (cls.len == 2'd3) ? S_B2_A : S_DONE;
         S_B2_A: next_state = S_B2_B;
         S_B2_B: next_state = S_DAT_A;
         S_DAT_A: next_state = S_DAT_B;
         S_DAT_B: next_state = S_DONE;
         S_DONE: next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
   end

   // program and data space requests
   wire next_prog_rd = (next_state == S_OPC_A) || (next_state == S_B1_A) ||
                       (next_state == S_B2_A);
   wire [11:0] next_prog_addr = (state == S_IDLE) ? PC_IN :
                                (next_state == S_B1_A) ? pc_q + 12'h001 :
                                pc_q + 12'h002;
   wire [7:0] index_addr = `OAD_WORK_BASE | {7'h00, op_w[4]};
   wire [7:0] next_data_addr = (cls.mode == oad_pkg::M_IND) ? index_addr : b1_w;

   // operand, branch condition and target
   wire [2:0] bit_w = op_w[2:0];
   wire cond_ok = op_w[6] ? (FLAG_Z_IN ^ op_w[5]) : (FLAG_C_IN ^ op_w[5]);
   wire btb_ok = dat_w[bit_w] == op_w[4];
   wire [11:0] seq_pc = pc_q + {10'h000, cls.len};
   wire [11:0] rel_tgt = op_w[4] ? pc_q - {8'h00, op_w[3:0]} :
                         pc_q + {8'h00, op_w[3:0]} + 12'h001;
   wire [11:0] btb_tgt = pc_q + {{4{b2_w[7]}}, b2_w} + 12'h001;
   wire [11:0] ext_tgt = {op_w[3:0], b1_w};
   wire is_rel = cls.mode == oad_pkg::M_REL;
   wire is_btb = cls.mode == oad_pkg::M_BTB;
   wire is_ext = cls.mode == oad_pkg::M_EXT;
   wire taken = is_rel ? cond_ok : (is_btb ? btb_ok : is_ext);
   wire [11:0] target = is_rel ? rel_tgt : is_btb ? btb_tgt : is_ext ? ext_tgt : seq_pc;
   wire [7:0] sdir_addr = `OAD_WORK_BASE | {6'h00, op_w[1:0]};
   wire [7:0] operand = (cls.mode == oad_pkg::M_SDIR) ? sdir_addr :
                        (cls.mode == oad_pkg::M_IND) ? dat_w :
                        (cls.mode == oad_pkg::M_INH) ? 8'h00 :
                        b1_w;

   // data space region of the operand address
   oad_pkg::oad_region_e region;
   assign region = (cls.mode == oad_pkg::M_INH || is_rel || is_ext) ? oad_pkg::R_NONE :
                   (cls.mode == oad_pkg::M_IMM) ? oad_pkg::R_PROG :
                   (operand == `OAD_ACC_ADDR) ? oad_pkg::R_ACC :
                   (operand >= `OAD_WORK_BASE && operand <= `OAD_WORK_LAST) ? oad_pkg::R_WORK :
                   (operand >= `OAD_PERI_BASE) ? oad_pkg::R_PERI :
                   (operand >= `OAD_RAM_BASE) ? oad_pkg::R_RAM :
                   oad_pkg::R_DROM;

   assign next_decode.mode = cls.mode;
   assign next_decode.len = cls.len;
   assign next_decode.opcode = op_w;
   assign next_decode.operand = operand;
   assign next_decode.bitnum = bit_w;
   assign next_decode.target = target;
   assign next_decode.taken = taken;
   assign next_decode.region = region;

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESET_N_IN) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESET_N_IN) begin
         PROG_RD_OUT <= 1'b0;
         PROG_ADDR_OUT <= `OAD_PC_RESET;
         DATA_RD_OUT <= 1'b0;
         DATA_ADDR_OUT <= 8'h00;
      end else begin
         PROG_RD_OUT <= next_prog_rd;
         PROG_ADDR_OUT <= next_prog_rd ? next_prog_addr : PROG_ADDR_OUT;
         DATA_RD_OUT <= next_state == S_DAT_A;
         DATA_ADDR_OUT <= (next_state == S_DAT_A) ? next_data_addr : DATA_ADDR_OUT;
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESET_N_IN) begin
         pc_q <= `OAD_PC_RESET;
         opc_q <= 8'h00;
         b1_q <= 8'h00;
         b2_q <= 8'h00;
         dat_q <= 8'h00;
      end else begin
         pc_q <= (state == S_IDLE && START_IN) ? PC_IN : pc_q;
         opc_q <= op_w;
         b1_q <= b1_w;
         b2_q <= b2_w;
         dat_q <= dat_w;
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESET_N_IN) begin
         DONE_OUT <= 1'b0;
         DECODE_OUT <= '0;
         NEXT_PC_OUT <= `OAD_PC_RESET;
      end else begin
         DONE_OUT <= next_state == S_DONE;
         if (next_state == S_DONE) begin
            DECODE_OUT <= next_decode;
            NEXT_PC_OUT <= taken ? target : seq_pc;
         end
      end
   end

   assign BUSY_OUT = state != S_IDLE;

   // return stack: call pushes return address, interrupt push only when DONE_OUT is low
   wire call_push = DONE_OUT && DECODE_OUT.mode == oad_pkg::M_EXT && DECODE_OUT.opcode[4];
   wire [11:0] push_data = call_push ? pc_q + 12'h002 : PC_IN;

   oad_ret_stack #(
      .DEPTH(STACK_DEPTH),
      .W(`OAD_PC_W),
      .CW(SCW)
   ) u_stack (
      .clk_in(CORE_CLK_IN),
      .rst_n_in(RESET_N_IN),
      .push_in(call_push || (IRQ_PUSH_IN && !DONE_OUT)),
      .pop_in(RET_POP_IN),
      .data_in(push_data),
      .top_out(STACK_TOP_OUT),
      .count_out(stack_count),
      .full_out(STACK_FULL_OUT),
      .empty_out(STACK_EMPTY_OUT)
   );

   // checks
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   sequence seq_b1_fetch;
      PROG_RD_OUT && state == S_B1_A ##1 state == S_B1_B;
   endsequence
   sequence seq_btb_tail;
      ##2 state == S_B1_B ##2 state == S_B2_B ##2 state == S_DAT_B ##1 DONE_OUT;
   endsequence

   stack_bound_a: assert property (stack_count <= SCW'(STACK_DEPTH))
      else $error("return stack count above depth");
   region_work_a: assert property (DONE_OUT && DECODE_OUT.region != oad_pkg::R_NONE &&
      DECODE_OUT.mode != oad_pkg::M_IMM && DECODE_OUT.operand >= `OAD_WORK_BASE &&
      DECODE_OUT.operand <= `OAD_WORK_LAST |-> DECODE_OUT.region == oad_pkg::R_WORK)
      else $error("working register not mapped to its region");
   imm_operand_a: assert property (state == S_B1_B && cls.mode == oad_pkg::M_IMM |=>
      DONE_OUT && DECODE_OUT.operand == $past(PROG_DATA_IN) && DECODE_OUT.len == 2'd2)
      else $error("immediate operand not the byte after opcode");
   direct_addr_a: assert property (state == S_OPC_B && cls.mode == oad_pkg::M_DIR |=>
      seq_b1_fetch ##0 PROG_ADDR_OUT == pc_q + 12'h001 ##1 DONE_OUT)
      else $error("direct address byte not fetched after opcode");
   short_dir_a: assert property (DONE_OUT && DECODE_OUT.mode == oad_pkg::M_SDIR |->
      DECODE_OUT.operand[7:2] == 6'h20 && DECODE_OUT.len == 2'd1)
      else $error("short direct register outside 80h to 83h");
   ext_target_a: assert property (DONE_OUT && DECODE_OUT.mode == oad_pkg::M_EXT |->
      DECODE_OUT.target == {DECODE_OUT.opcode[3:0], b1_q} && NEXT_PC_OUT == DECODE_OUT.target
      && DECODE_OUT.len == 2'd2)
      else $error("extended target wrong");
   call_push_a: assert property (call_push && !STACK_FULL_OUT |=>
      stack_count == SCW'($past(stack_count) + 1'b1) &&
      STACK_TOP_OUT == $past(pc_q) + 12'h002)
      else $error("call did not push its return address");
   rel_fall_a: assert property (DONE_OUT && DECODE_OUT.mode == oad_pkg::M_REL &&
      !DECODE_OUT.taken |-> NEXT_PC_OUT == pc_q + 12'h001)
      else $error("untaken branch not falling through");
   rel_back_a: assert property (DONE_OUT && DECODE_OUT.mode == oad_pkg::M_REL &&
      DECODE_OUT.taken && DECODE_OUT.opcode[4] |->
      NEXT_PC_OUT == pc_q - {8'h00, DECODE_OUT.opcode[3:0]})
      else $error("backward branch target wrong");
   bit_direct_a: assert property (DONE_OUT && DECODE_OUT.mode == oad_pkg::M_BDIR |->
      DECODE_OUT.bitnum == DECODE_OUT.opcode[2:0] && DECODE_OUT.operand == b1_q &&
      DECODE_OUT.len == 2'd2)
      else $error("bit direct fields wrong");
   btb_seq_a: assert property (state == S_OPC_B && cls.mode == oad_pkg::M_BTB |->
      seq_btb_tail)
      else $error("bit test branch not fetched as three bytes");
   index_sel_a: assert property (state == S_OPC_B && cls.mode == oad_pkg::M_IND |=>
      DATA_RD_OUT && DATA_ADDR_OUT == (`OAD_WORK_BASE | {7'h00, $past(PROG_DATA_IN[4])}))
      else $error("indirect index register not selected by bit 4");
   inherent_a: assert property (state == S_OPC_B && cls.mode == oad_pkg::M_INH |=>
      DONE_OUT && !PROG_RD_OUT && !DATA_RD_OUT)
      else $error("inherent instruction fetched an operand");
   len_first_a: assert property (state == S_OPC_B |=>
      PROG_RD_OUT == ($past(cls_len) != 2'd1))
      else $error("operand fetch disagrees with opcode length");
   rel_fwd_a: assert property (DONE_OUT && DECODE_OUT.mode == oad_pkg::M_REL &&
      DECODE_OUT.taken && !DECODE_OUT.opcode[4] |->
      NEXT_PC_OUT == pc_q + {8'h00, DECODE_OUT.opcode[3:0]} + 12'h001)
      else $error("forward branch target wrong");
   btb_target_a: assert property (DONE_OUT && DECODE_OUT.mode == oad_pkg::M_BTB |->
      NEXT_PC_OUT == (DECODE_OUT.taken ? pc_q + {{4{b2_q[7]}}, b2_q} + 12'h001 :
      pc_q + 12'h003))
      else $error("bit test branch destination wrong");
   irq_push_a: assert property (IRQ_PUSH_IN && !DONE_OUT && !STACK_FULL_OUT |=>
      STACK_TOP_OUT == $past(PC_IN) &&
      stack_count == SCW'($past(stack_count) + 1'b1))
      else $error("interrupt push lost or wrong");
   done_pulse_a: assert property (DONE_OUT |=> !DONE_OUT && !BUSY_OUT)
      else $error("done not a single pulse ending the decode");
endmodule : oad_decoder
`default_nettype wire

//--- tb/oad_mem_model.sv
// program memory and data space model answering the decoder's read strobes
`timescale 1ns/100ps
`default_nettype none
module oad_mem_model (
   input wire logic clk_in,
   input wire logic prog_rd_in,
   input wire logic [11:0] prog_addr_in,
   output logic [7:0] prog_data_out,
   input wire logic data_rd_in,
   input wire logic [7:0] data_addr_in,
   output logic [7:0] data_out
);
   logic [7:0] prog [0:4095];
   logic [7:0] dmem [0:255];
   initial begin
      prog_data_out = 8'h00;
      data_out = 8'h00;
   end
   // program byte one cycle after strobe, scrambled otherwise
   always @(posedge clk_in) begin
      if (prog_rd_in) begin
         prog_data_out <= #5 prog[prog_addr_in];
      end else begin
         prog_data_out <= #5 ~prog_data_out;
      end
   end
   // data space byte one cycle after strobe, scrambled otherwise
   always @(posedge clk_in) begin
      if (data_rd_in) begin
         data_out <= #5 dmem[data_addr_in];
      end else begin
         data_out <= #5 ~data_out;
      end
   end
endmodule : oad_mem_model
`default_nettype wire

//--- tb/oad_decoder_test.sv
// self-checking bench for the operand addressing decoder
`timescale 1ns/100ps
`default_nettype none
module oad_decoder_test;
   logic CORE_CLK_IN, RESET_N_IN, START_IN, FLAG_Z_IN, FLAG_C_IN, IRQ_PUSH_IN, RET_POP_IN;
   logic [11:0] PC_IN, PROG_ADDR_OUT, NEXT_PC_OUT, STACK_TOP_OUT;
   logic PROG_RD_OUT, DATA_RD_OUT, BUSY_OUT, DONE_OUT, STACK_FULL_OUT, STACK_EMPTY_OUT;
   logic [7:0] PROG_DATA_IN, DATA_ADDR_OUT, DATA_IN;
   oad_pkg::oad_decode_s DECODE_OUT;
   int fails = 0;
   int checks_done = 0;
   oad_decoder u_dut (.CORE_CLK_IN(CORE_CLK_IN), .RESET_N_IN(RESET_N_IN), .START_IN(START_IN),
      .PC_IN(PC_IN), .FLAG_Z_IN(FLAG_Z_IN), .FLAG_C_IN(FLAG_C_IN), .IRQ_PUSH_IN(IRQ_PUSH_IN),
      .RET_POP_IN(RET_POP_IN), .PROG_RD_OUT(PROG_RD_OUT), .PROG_ADDR_OUT(PROG_ADDR_OUT),
      .PROG_DATA_IN(PROG_DATA_IN), .DATA_RD_OUT(DATA_RD_OUT), .DATA_ADDR_OUT(DATA_ADDR_OUT),
      .DATA_IN(DATA_IN), .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT), .DECODE_OUT(DECODE_OUT),
      .NEXT_PC_OUT(NEXT_PC_OUT), .STACK_TOP_OUT(STACK_TOP_OUT),
      .STACK_FULL_OUT(STACK_FULL_OUT), .STACK_EMPTY_OUT(STACK_EMPTY_OUT));
   oad_mem_model u_mem (.clk_in(CORE_CLK_IN), .prog_rd_in(PROG_RD_OUT),
      .prog_addr_in(PROG_ADDR_OUT), .prog_data_out(PROG_DATA_IN), .data_rd_in(DATA_RD_OUT),
      .data_addr_in(DATA_ADDR_OUT), .data_out(DATA_IN));
   initial begin
      CORE_CLK_IN = 1'b0;
      forever #25 CORE_CLK_IN = ~CORE_CLK_IN;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick();
      @(posedge CORE_CLK_IN);
      #5;
   endtask : tick
   // one decode from pc; returns in the cycle where the done pulse stands
   task automatic run(input logic [11:0] pc, input logic [7:0] b0, input logic [7:0] b1,
         input logic [7:0] b2, input int cyc);
      int n;
      n = 1;
      u_mem.prog[pc] = b0;
      u_mem.prog[pc + 12'h001] = b1;
      u_mem.prog[pc + 12'h002] = b2;
      tick();
      START_IN = 1'b1;
      PC_IN = pc;
      tick();
      START_IN = 1'b0;
      chk(16'(BUSY_OUT), 16'h0001);
      while (DONE_OUT !== 1'b1 && n < 20) begin
         tick();
         n++;
      end
      if (n >= 20) begin
         fails++;
         test_done();
      end
      chk(16'(n), 16'(cyc));
   endtask : run
   function automatic logic [2:0] rgn(input logic [7:0] a);
      if (a == 8'hFF) return 3'(oad_pkg::R_ACC);
      if (a >= 8'h80 && a <= 8'h83) return 3'(oad_pkg::R_WORK);
      if (a >= 8'hC0) return 3'(oad_pkg::R_PERI);
      if (a >= 8'h40) return 3'(oad_pkg::R_RAM);
      return 3'(oad_pkg::R_DROM);
   endfunction : rgn
   task automatic t_basic();
      logic [7:0] adr [6];
      adr = '{8'hFF, 8'h81, 8'hC0, 8'h7F, 8'h84, 8'h3F};
      chk(16'(STACK_EMPTY_OUT), 16'h0001);
      chk(16'(STACK_TOP_OUT), 16'h0000);
      run(12'h010, 8'hE3, 8'h00, 8'h00, 3);
      chk(16'(DECODE_OUT.mode), 16'(oad_pkg::M_INH));
      chk(16'(DECODE_OUT.len), 16'h0001);
      chk(16'(NEXT_PC_OUT), 16'h0011);
      run(12'h020, 8'hC0, 8'h5A, 8'h00, 5);
      chk(16'(DECODE_OUT.operand), 16'h005A);
      chk(16'(DECODE_OUT.region), 16'(oad_pkg::R_PROG));
      chk(16'(DECODE_OUT.len), 16'h0002);
      foreach (adr[i]) begin
         run(12'h030, 8'hC8, adr[i], 8'h00, 5);
         chk(16'(DECODE_OUT.mode), 16'(oad_pkg::M_DIR));
         chk(16'(DECODE_OUT.region), 16'(rgn(adr[i])));
         chk(16'(NEXT_PC_OUT), 16'h0032);
      end
      for (int r = 0; r < 4; r++) begin
         run(12'h040, 8'hD0 | 8'(r), 8'h00, 8'h00, 3);
         chk(16'(DECODE_OUT.mode), 16'(oad_pkg::M_SDIR));
         chk(16'(DECODE_OUT.region), 16'(oad_pkg::R_WORK));
         chk(16'(DECODE_OUT.len), 16'h0001);
      end
      $display("test basic modes done");
   endtask : t_basic
   task automatic t_ext();
      run(12'h050, 8'h8A, 8'h34, 8'h00, 5);
      chk(16'(DECODE_OUT.target), 16'h0A34);
      chk(16'(NEXT_PC_OUT), 16'h0A34);
      chk(16'(DECODE_OUT.len), 16'h0002);
      run(12'h060, 8'h9F, 8'hFF, 8'h00, 5);
      chk(16'(NEXT_PC_OUT), 16'h0FFF);
      tick();
      chk(16'(STACK_TOP_OUT), 16'h0062);
      RET_POP_IN = 1'b1;
      tick();
      RET_POP_IN = 1'b0;
      tick();
      chk(16'(STACK_EMPTY_OUT), 16'h0001);
      $display("test extended done");
   endtask : t_ext
   task automatic t_rel();
      logic tk;
      for (int c = 0; c < 4; c++) begin
         for (int d = 0; d < 2; d++) begin
            tk = 1'(d) == 1'(c);
            FLAG_C_IN = tk ^ 1'(c);
            FLAG_Z_IN = tk ^ 1'(c);
            run(12'h100, {3'(c), 1'(d), 4'hF}, 8'h00, 8'h00, 3);
            chk(16'(DECODE_OUT.mode), 16'(oad_pkg::M_REL));
            chk(16'(DECODE_OUT.target), (d == 0) ? 16'h0110 : 16'h00F1);
            chk(16'(DECODE_OUT.taken), 16'(tk));
            chk(16'(NEXT_PC_OUT), tk ? ((d == 0) ? 16'h0110 : 16'h00F1) : 16'h0101);
         end
      end
      $display("test relative done");
   endtask : t_rel
   task automatic t_bit();
      u_mem.dmem[8'h90] = 8'h08;
      run(12'h070, 8'hA5, 8'h77, 8'h00, 5);
      chk(16'(DECODE_OUT.mode), 16'(oad_pkg::M_BDIR));
      chk(16'(DECODE_OUT.bitnum), 16'h0005);
      chk(16'(DECODE_OUT.operand), 16'h0077);
      chk(16'(DECODE_OUT.len), 16'h0002);
      run(12'h200, 8'hBB, 8'h90, 8'h80, 9);
      chk(16'(DECODE_OUT.len), 16'h0003);
      chk(16'(NEXT_PC_OUT), 16'h0181);
      run(12'h200, 8'hAB, 8'h90, 8'h7F, 9);
      chk(16'(DECODE_OUT.target), 16'h0280);
      chk(16'(NEXT_PC_OUT), 16'h0203);
      u_mem.dmem[8'h80] = 8'h3C;
      u_mem.dmem[8'h81] = 8'hC7;
      run(12'h080, 8'hE8, 8'h00, 8'h00, 5);
      chk(16'(DECODE_OUT.operand), 16'h003C);
      run(12'h080, 8'hF8, 8'h00, 8'h00, 5);
      chk(16'(DECODE_OUT.operand), 16'h00C7);
      chk(16'(DECODE_OUT.len), 16'h0001);
      $display("test bit and indirect done");
   endtask : t_bit
   task automatic t_stack();
      tick();
      chk(16'(BUSY_OUT), 16'h0000);
      for (int i = 0; i < 7; i++) begin
         IRQ_PUSH_IN = 1'b1;
         PC_IN = 12'h300 + 12'(i);
         tick();
         IRQ_PUSH_IN = 1'b0;
         tick();
      end
      chk(16'(STACK_FULL_OUT), 16'h0001);
      chk(16'(STACK_TOP_OUT), 16'h0305);
      for (int i = 0; i < 6; i++) begin
         RET_POP_IN = 1'b1;
         tick();
         RET_POP_IN = 1'b0;
         tick();
      end
      chk(16'(STACK_EMPTY_OUT), 16'h0001);
      $display("test stack done");
   endtask : t_stack
   initial begin
      RESET_N_IN = 1'b0;
      START_IN = 1'b0;
      PC_IN = 12'h000;
      FLAG_Z_IN = 1'b0;
      FLAG_C_IN = 1'b0;
      IRQ_PUSH_IN = 1'b0;
      RET_POP_IN = 1'b0;
      repeat (12) @(posedge CORE_CLK_IN);
      #5;
      RESET_N_IN = 1'b1;
      t_basic();
      t_ext();
      t_rel();
      t_bit();
      t_stack();
      test_done();
   end
endmodule : oad_decoder_test
`default_nettype wire
